// [logic/usb_irq_pkg.sv]
package usb_irq_pkg;

   // Bus geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_IN_FLAGS   = 16'h7fa9;
   localparam logic [15:0] IDX_OUT_FLAGS  = 16'h7faa;
   localparam logic [15:0] IDX_DEV_FLAGS  = 16'h7fab;
   localparam logic [15:0] IDX_IN_EN      = 16'h7fac;
   localparam logic [15:0] IDX_OUT_EN     = 16'h7fad;
   localparam logic [15:0] IDX_DEV_EN     = 16'h7fae;
   localparam logic [15:0] IDX_VECTOR     = 16'h7faf;
   localparam logic [15:0] IDX_AV_CTRL    = 16'h7fb0;
   localparam logic [15:0] IDX_CPU_FLAGS  = 16'h7fb1;
   localparam logic [15:0] IDX_CPU_EN     = 16'h7fb2;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h7fb3;
   localparam logic [15:0] IDX_IRQ_MASK   = 16'h7fb4;

   // Field positions
   localparam int CPU_FLAG_BIT  = 4;
   localparam int CPU_EN_BIT    = 0;
   localparam int AV_EN_BIT     = 0;
   localparam int EV_PULSE_BIT  = 0;
   localparam int EV_MERGE_BIT  = 1;
   localparam int EV_SUBST_BIT  = 2;

   // Source counts and priority slot layout
   localparam int NUM_DEV   = 5;
   localparam int NUM_EP    = 8;
   localparam int NUM_SLOTS = 22;
   localparam int IDX_W     = 5;
   localparam int SLOT_GAP  = 5;
   localparam int SLOT_EP   = 6;
   localparam int NUM_EV    = 3;

   // Autovector substitution address
   localparam logic [15:0] AUTOVEC_ADDR = 16'h0045;

   // Reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [4:0] RST_DEV    = 5'h00;
   localparam logic [2:0] RST_EV     = 3'h0;

   // Bus handshake states
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_e;

endpackage

// [logic/source_priority_encoder.sv]
`timescale 1ns/10ps
module source_priority_encoder #(
   parameter int N = 22,
   parameter int W = 5
) (
   input  logic [N-1:0] req,
   output logic         found,
   output logic [W-1:0] index
);

   // Lowest set position wins; scan from the top so it is written last
   always_comb begin
      found = |req;
      index = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            index = W'(i);
         end
      end
   end

endmodule // source_priority_encoder

// [logic/usb_interrupt_aggregator.sv]
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
// Function
// R01 - All 21 sources share one request line
// R02 - Per-source latch, write 1 clears it
// R03 - Latch AND enable, then OR together
// R04 - Five-bit index, 00 highest, to vector
// R05 - Simultaneous requests show highest priority first
// R06 - Vector replaces code byte at 0x45
// R07 - Gated source sets cpu flag, enable gates
// R08 - Cpu flag cleared by writing 0
// R09 - Service need gives single pulse, not level
// R10 - Clearing latch re-pulses for remaining pending
// R11 - Order setup-data-valid first, endpoint 7 OUT last
// R12 - Processor clears flag before clearing latch
// R13 - Endpoint n request at bit n
// R14 - Device-wide pair holds five sources, bits 0-4
// R15 - Substitution only while autovector enable set
// R16 - Vector byte is index times four
// R17 - Device enable mirrors device request layout
// R18 - No pulse idle; late enable gives pulse
module usb_interrupt_aggregator (
   input  logic                           clk,
   input  logic                           resetn,
   input  logic [usb_irq_pkg::ADDR_W-1:0] avs_address,
   input  logic                           avs_read,
   input  logic                           avs_write,
   input  logic [usb_irq_pkg::DATA_W-1:0] avs_writedata,
   input  logic [3:0]                     avs_byteenable,
   output logic [usb_irq_pkg::DATA_W-1:0] avs_readdata,
   output logic                           avs_waitrequest,
   input  logic [usb_irq_pkg::NUM_DEV-1:0] device_event_set,
   input  logic [usb_irq_pkg::NUM_EP-1:0] in_ep_set,
   input  logic [usb_irq_pkg::NUM_EP-1:0] out_ep_set,
   input  logic [15:0]                    code_addr,
   input  logic [7:0]                     code_byte,
   output logic [7:0]                     fetch_byte,
   output logic                           shared_usb_cpu_irq_input,
   output logic                           cpu_usb_irq,
   output logic                           irq
);
   import usb_irq_pkg::*;

   // Address decode shared by every register select
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [15:0] idx);
      return a == ADDR_W'({idx, 2'b00});
   endfunction

   // Request latches, one per source
   logic [NUM_DEV-1:0] dev_lat_r;     // Device-wide requests
   logic [NUM_EP-1:0]  in_lat_r;      // IN endpoint requests
   logic [NUM_EP-1:0]  out_lat_r;     // OUT endpoint requests
   logic [NUM_DEV-1:0] dev_lat_nxt;
   logic [NUM_EP-1:0]  in_lat_nxt;
   logic [NUM_EP-1:0]  out_lat_nxt;

   // Enable registers
   logic [NUM_DEV-1:0] dev_en_r;      // Same layout as requests
   logic [NUM_EP-1:0]  in_en_r;
   logic [NUM_EP-1:0]  out_en_r;

   // Processor-side state
   logic               cpu_flag_r;    // Shared request flag
   logic               cpu_en_r;      // Shared interrupt enable
   logic               autovector_enable_r;        // Autovector enable
   logic [7:0]         vector_r;      // Vector register
   logic [7:0]         fetch_r;       // Code byte as delivered
   logic               pulse_r;       // Edge input pulse
   logic               pend_r;        // Pulse owed while one is still high
   logic               clr_hit_r;     // A latch was cleared last cycle
   logic [NUM_SLOTS-1:0] gated_prev_r;// Gated requests, previous cycle

   // Event status and mask
   logic [NUM_EV-1:0]  ev_stat_r;
   logic [NUM_EV-1:0]  ev_mask_r;
   logic [NUM_EV-1:0]  ev_set;

   // Bus handshake
   bus_state_e         bus_st_r;
   logic [DATA_W-1:0]  rdata_r;

   // Decode results
   // Every access spends one wait cycle and one acknowledge cycle; side
   // effects such as clears happen only in the acknowledge cycle, so a
   // master holding its request until waitrequest drops acts exactly once
   wire bus_req = avs_read | avs_write;
   wire bus_go  = (bus_st_r == BUS_ACK) & bus_req;
   wire wr_go   = bus_go & avs_write & avs_byteenable[0];
   wire rd_go   = bus_go & avs_read;
   wire [7:0] wbyte = avs_writedata[7:0];

   // One select per word; an address with low bits set hits nothing
   wire hit_in_f  = reg_hit(avs_address, IDX_IN_FLAGS);
   wire hit_out_f = reg_hit(avs_address, IDX_OUT_FLAGS);
   wire hit_dev_f = reg_hit(avs_address, IDX_DEV_FLAGS);
   wire hit_in_e  = reg_hit(avs_address, IDX_IN_EN);
   wire hit_out_e = reg_hit(avs_address, IDX_OUT_EN);
   wire hit_dev_e = reg_hit(avs_address, IDX_DEV_EN);
   wire hit_vec   = reg_hit(avs_address, IDX_VECTOR);
   wire hit_av    = reg_hit(avs_address, IDX_AV_CTRL);
   wire hit_cpu_f = reg_hit(avs_address, IDX_CPU_FLAGS);
   wire hit_cpu_e = reg_hit(avs_address, IDX_CPU_EN);
   wire hit_stat  = reg_hit(avs_address, IDX_IRQ_STATUS);
   wire hit_mask  = reg_hit(avs_address, IDX_IRQ_MASK);

   // Write-one-to-clear masks; a written 0 leaves a latch alone
   // Only lane 0 carries register data, so software must not rely on
   // the upper bytes of a word
   wire [NUM_EP-1:0]  in_clr  = (wr_go & hit_in_f)  ? wbyte : RST_BYTE; // R02 R13
   wire [NUM_EP-1:0]  out_clr = (wr_go & hit_out_f) ? wbyte : RST_BYTE; // R02 R13
   wire [NUM_DEV-1:0] dev_clr =
      (wr_go & hit_dev_f) ? wbyte[NUM_DEV-1:0] : RST_DEV;                // R02 R14

   // Set wins over a clear landing in the same cycle
   // Losing the set instead would drop a request that software never saw
   assign dev_lat_nxt = (dev_lat_r & ~dev_clr) | device_event_set;       // R02
   assign in_lat_nxt  = (in_lat_r & ~in_clr) | in_ep_set;                // R02
   assign out_lat_nxt = (out_lat_r & ~out_clr) | out_ep_set;             // R02

   // A clear that really dropped a set latch
   // Clearing a bit that was already low must not re-pulse the core
   // Clears that lose to a same-cycle set are not counted either
   wire clr_hit = |(dev_lat_r & dev_clr & ~device_event_set)
                | |(in_lat_r & in_clr & ~in_ep_set)
                | |(out_lat_r & out_clr & ~out_ep_set);

   // Gated requests laid out in priority order
   logic [NUM_SLOTS-1:0] gated;
   assign gated[NUM_DEV-1:0] = dev_lat_r & dev_en_r;                     // R03 R14 R17
   // Slot 5 has no source; keeping it empty puts endpoint 0 IN at
   // vector 0x18, so the jump table keeps its layout
   assign gated[SLOT_GAP]    = 1'b0;

   // Endpoint n IN at slot 6+2n, OUT at 7+2n; slot 21 is last
   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++) begin : g_ep_slot
         assign gated[SLOT_EP + 2*g]     = in_lat_r[g] & in_en_r[g];    // R03 R11
         assign gated[SLOT_EP + 2*g + 1] = out_lat_r[g] & out_en_r[g];  // R03 R11
      end
   endgenerate

   // Single shared request: the OR of every gated source
   // Disabled sources still latch, but stay out of the OR and the vector
   wire any_req = |gated;                                                // R01 R03

   // Highest-priority pending slot
   // Lowest slot number wins; the result is registered into the vector
   // one cycle after the request appears
   logic             win_found;
   logic [IDX_W-1:0] win_idx;
   source_priority_encoder #(
      .N (NUM_SLOTS),
      .W (IDX_W)
   ) u_prio (
      .req   (gated),
      .found (win_found),
      .index (win_idx)
   );

   // Vector byte: index shifted up two, low bits zero
   // Four bytes per entry leaves room for one jump in each table slot
   wire [7:0] vec_nxt = win_found ? {1'b0, win_idx, 2'b00} : RST_BYTE;   // R04 R05 R16

   // New requests, including ones newly enabled
   wire newly = |(gated & ~gated_prev_r);                                // R09 R18
   // Re-pulse after a clear while others still pend
   wire repulse = clr_hit_r & any_req;                                   // R10
   // A cause arriving while the pulse is high is owed, not merged: the
   // edge input must see a low cycle between two pulses to count both
   wire pulse_want = newly | repulse | pend_r;                           // R09 R18
   wire pulse_nxt  = pulse_want & ~pulse_r;                              // R09 R18
   wire pend_nxt   = pulse_want & pulse_r;                               // R09

   // Substitution only at the vector slot and only when enabled
   // Limitation: every fetch of that address is altered, not only the
   // one that follows taking the interrupt
   wire subst = autovector_enable_r & (code_addr == AUTOVEC_ADDR);                    // R06 R15

   // Cpu flag: pulse sets, writing 0 to its bit clears, set wins
   // Writing 1 leaves it alone, the reverse of the source latches
   wire cpu_clr = wr_go & hit_cpu_f & ~wbyte[CPU_FLAG_BIT];              // R08
   wire cpu_flag_nxt = pulse_r | (cpu_flag_r & ~cpu_clr);                // R07 R08

   // Events for the block interrupt
   assign ev_set[EV_PULSE_BIT] = pulse_r;
   // Pulse landing on an already set flag is merged and lost
   assign ev_set[EV_MERGE_BIT] = pulse_r & cpu_flag_r;                   // R12
   assign ev_set[EV_SUBST_BIT] = subst;

   // Read clear of status only when that word is really read, and only
   // of the bits the read returned: an event landing between capture
   // and acknowledge survives to the next read
   wire [NUM_EV-1:0] ev_clr = (rd_go & hit_stat) ? rdata_r[NUM_EV-1:0] : RST_EV;

   // Read mux; unmapped words read as zero
   // Reserved bits read zero so software may compare whole bytes
   wire [7:0] rd_byte =
      hit_in_f  ? in_lat_r :
      hit_out_f ? out_lat_r :
      hit_dev_f ? {3'b000, dev_lat_r} :
      hit_in_e  ? in_en_r :
      hit_out_e ? out_en_r :
      hit_dev_e ? {3'b000, dev_en_r} :
      hit_vec   ? vector_r :
      hit_av    ? {7'h00, autovector_enable_r} :
      hit_cpu_f ? {3'b000, cpu_flag_r, 4'h0} :
      hit_cpu_e ? {7'h00, cpu_en_r} :
      hit_stat  ? {5'h00, ev_stat_r} :
      hit_mask  ? {5'h00, ev_mask_r} :
      RST_BYTE;

   // Bus: every access waits exactly one cycle, then completes
   // The fixed wait gives the read mux a full cycle to settle
   // and keeps the handshake the same for reads and writes
   always_ff @(posedge clk) begin
      if (!resetn) begin
         bus_st_r <= BUS_IDLE;
      end else if (bus_st_r == BUS_ACK) begin
         bus_st_r <= BUS_IDLE;
      end else if (bus_req) begin
         bus_st_r <= BUS_ACK;
      end
   end

   // Read data captured in the wait cycle, stands during acknowledge
   // and is held afterwards until the next read
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_r <= '0;
      end else if (bus_st_r == BUS_IDLE && avs_read) begin
         rdata_r <= {24'h000000, rd_byte};
      end
   end

   assign avs_waitrequest = bus_req & (bus_st_r != BUS_ACK);
   assign avs_readdata    = rdata_r;

   // Request latches
   // Set and clear are merged in the next-state logic above
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dev_lat_r <= RST_DEV;
         in_lat_r  <= RST_BYTE;
         out_lat_r <= RST_BYTE;
      end else begin
         dev_lat_r <= dev_lat_nxt;
         in_lat_r  <= in_lat_nxt;
         out_lat_r <= out_lat_nxt;
      end
   end

   // Enables, written whole
   // Changing an enable never touches its latch; enabling a set latch
   // raises the gated request and so gives a pulse
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dev_en_r <= RST_DEV;
         in_en_r  <= RST_BYTE;
         out_en_r <= RST_BYTE;
      end else if (wr_go) begin
         if (hit_dev_e) dev_en_r <= wbyte[NUM_DEV-1:0];                   // R17
         if (hit_in_e)  in_en_r  <= wbyte;                                // R13
         if (hit_out_e) out_en_r <= wbyte;                                // R13
      end
   end

   // Processor-side control bits
   // Only bit 0 of each word is kept; the rest read back as zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cpu_en_r <= 1'b0;
         autovector_enable_r   <= 1'b0;
      end else if (wr_go) begin
         if (hit_cpu_e) cpu_en_r <= wbyte[CPU_EN_BIT];                    // R07
         if (hit_av)    autovector_enable_r   <= wbyte[AV_EN_BIT];                     // R15
      end
   end

   // Cpu flag
   // If software clears the flag after the latch, a re-pulse can land
   // on a flag still set and that request is lost
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cpu_flag_r <= 1'b0;
      end else begin
         cpu_flag_r <= cpu_flag_nxt;                                      // R07 R08
      end
   end

   // Pulse generation and vector tracking
   // Low reset values keep the edge input from seeing a false edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pulse_r      <= 1'b0;
         pend_r       <= 1'b0;
         clr_hit_r    <= 1'b0;
         gated_prev_r <= '0;
         vector_r     <= RST_BYTE;
      end else begin
         pulse_r      <= pulse_nxt;                                       // R09 R10
         pend_r       <= pend_nxt;                                        // R09
         clr_hit_r    <= clr_hit;
         gated_prev_r <= gated;
         vector_r     <= vec_nxt;                                         // R04 R05
      end
   end

   // Code byte path, registered so the fetch sees one cycle latency
   // The vector used is the one registered before the fetch address
   // Code byte is passed through unchanged at any other address
   always_ff @(posedge clk) begin
      if (!resetn) begin
         fetch_r <= RST_BYTE;
      end else begin
         fetch_r <= subst ? vector_r : code_byte;                         // R06
      end
   end

   // Sticky events, read clears, set wins
   // Mask only gates the output; status bits set whatever the mask,
   // so software can poll them with the output masked
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ev_stat_r <= RST_EV;
         ev_mask_r <= RST_EV;
      end else begin
         ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
         if (wr_go && hit_mask) begin
            ev_mask_r <= wbyte[NUM_EV-1:0];
         end
      end
   end

   // Outputs
   // These outputs come from flip-flops, an AND of two of them, or an OR of masked status bits
   assign shared_usb_cpu_irq_input = pulse_r;                             // R09
   assign cpu_usb_irq = cpu_flag_r & cpu_en_r;                            // R07
   assign fetch_byte  = fetch_r;
   assign irq         = |(ev_stat_r & ev_mask_r);

endmodule // usb_interrupt_aggregator

// [bench/usb_irq_props.sv]
`timescale 1ns/10ps
// Port checks on the interrupt aggregator
module usb_irq_props import usb_irq_pkg::*; (
   input logic               clk,
   input logic               resetn,
   input logic               avs_read,
   input logic               avs_write,
   input logic [DATA_W-1:0]  avs_readdata,
   input logic               avs_waitrequest,
   input logic [NUM_DEV-1:0] device_event_set,
   input logic [NUM_EP-1:0]  in_ep_set,
   input logic [NUM_EP-1:0]  out_ep_set,
   input logic [15:0]        code_addr,
   input logic [7:0]         code_byte,
   input logic [7:0]         fetch_byte,
   input logic               shared_usb_cpu_irq_input,
   input logic               cpu_usb_irq,
   input logic               irq
);
   wire pls = shared_usb_cpu_irq_input; // Short alias
   // No write and no source set; such cycles give no cause for a pulse
   wire quiet = !avs_write && !(|{device_event_set, in_ep_set, out_ep_set});
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_PULSE_ONE: assert property (pls |=> !pls)
      else $error("irq pulse longer than one cycle");
   AST_QUIET: assert property (quiet [*4] |-> !pls)
      else $error("pulse without a cause");
   AST_CPU_RISE: assert property ($rose(cpu_usb_irq) |-> $past(pls) || $past(avs_write))
      else $error("cpu irq rose with no pulse or write");
   AST_FETCH_PASS: assert property ($past(resetn) && $past(code_addr) != AUTOVEC_ADDR
      |-> fetch_byte == $past(code_byte)) else $error("code byte altered");
   AST_FETCH_VEC: assert property ($past(resetn) && $past(code_addr) == AUTOVEC_ADDR
      && fetch_byte != $past(code_byte) |-> fetch_byte[1:0] == 2'b00 && fetch_byte <= 8'h54)
      else $error("bad vector byte");
   AST_RST_QUIET: assert property (!$past(resetn) |-> !pls && !cpu_usb_irq && !irq)
      else $error("output high after reset");
   AST_ACK_NEXT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus not answered after one wait");
   AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest while idle");
   AST_RD_HIGH: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   cover property (pls ##[2:40] pls);
   cover property ($rose(cpu_usb_irq));
   cover property ($rose(irq));
endmodule // usb_irq_props
bind usb_interrupt_aggregator usb_irq_props usb_irq_props_inst (.clk(clk), .resetn(resetn),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .device_event_set(device_event_set),
   .in_ep_set(in_ep_set), .out_ep_set(out_ep_set), .code_addr(code_addr),
   .code_byte(code_byte), .fetch_byte(fetch_byte), .cpu_usb_irq(cpu_usb_irq), .irq(irq),
   .shared_usb_cpu_irq_input(shared_usb_cpu_irq_input));

// [bench/cpu_irq_model.sv]
`timescale 1ns/10ps
// Edge-triggered interrupt input of the processor core
module cpu_irq_model (
   input  logic       clk,
   input  logic       resetn,
   input  logic       irq_edge,
   output logic [7:0] pulse_cnt
);
   logic prev_r; // Last sampled level
   // Counts rising edges only; a held level counts once, as on real silicon
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_r    <= 1'b0;
         pulse_cnt <= 8'h00;
      end else begin
         prev_r <= irq_edge;
         if (irq_edge && !prev_r) begin
            pulse_cnt <= pulse_cnt + 8'h01;
         end
      end
   end
endmodule // cpu_irq_model

// [bench/usb_interrupt_aggregator_tb.sv]
`timescale 1ns/10ps
// Randomised register-level bench for the interrupt aggregator
module usb_interrupt_aggregator_tb;
   import usb_irq_pkg::*;
   logic              clk, resetn, avs_read, avs_write, avs_waitrequest;
   logic              shared_usb_cpu_irq_input, cpu_usb_irq, irq;
   logic [ADDR_W-1:0] avs_address;
   logic [DATA_W-1:0] avs_writedata, avs_readdata;
   logic [3:0]        avs_byteenable;
   logic [4:0]        device_event_set;
   logic [7:0]        in_ep_set, out_ep_set, code_byte, fetch_byte, rd_q, base, exp_b;
   logic [15:0]       code_addr;
   logic [7:0]        pulse_cnt;
   int                n_mismatch = 0, checks_done = 0, seed = 32'hf5d59bc6;
   int                s, t, w, r, a, b;
   usb_interrupt_aggregator usb_interrupt_aggregator_inst (.clk(clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .device_event_set(device_event_set), .in_ep_set(in_ep_set), .out_ep_set(out_ep_set),
      .code_addr(code_addr), .code_byte(code_byte), .fetch_byte(fetch_byte),
      .shared_usb_cpu_irq_input(shared_usb_cpu_irq_input), .cpu_usb_irq(cpu_usb_irq), .irq(irq));
   cpu_irq_model cpu_irq_model_inst (.clk(clk), .resetn(resetn),
      .irq_edge(shared_usb_cpu_irq_input), .pulse_cnt(pulse_cnt));
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task check(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         n_mismatch++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One bus cycle, held until waitrequest is seen low; read data lands in rd_q
   task bus(input logic [15:0] idx, input logic wr, input logic [7:0] d);
      @(posedge clk);
      avs_address <= ADDR_W'({idx, 2'b00});
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'($random(seed)), d};
      avs_byteenable <= {3'($random(seed)), 1'b1};
      for (w = 0; w < 50; w++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (w == 50) check(8'h00, 8'hff);
      rd_q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Sources 0-4 device events, 5-12 IN endpoints, 13-20 OUT endpoints
   task raise(input logic [20:0] m);
      @(posedge clk);
      {out_ep_set, in_ep_set, device_event_set} <= m;
      @(posedge clk);
      {out_ep_set, in_ep_set, device_event_set} <= 21'h0;
      repeat (4) @(posedge clk);
   endtask
   function automatic int slot(input int s);
      return s < 5 ? s : s < 13 ? 6 + 2 * (s - 5) : 7 + 2 * (s - 13);
   endfunction
   function automatic logic [15:0] fidx(input int s);
      return s < 5 ? IDX_DEV_FLAGS : s < 13 ? IDX_IN_FLAGS : IDX_OUT_FLAGS;
   endfunction
   function automatic logic [7:0] fbit(input int s);
      return 8'h01 << (s < 5 ? s : s < 13 ? s - 5 : s - 13);
   endfunction
   // Watchdog, well past the expected run length
   initial begin
      #100000;
      n_mismatch++;
      wrap_up;
   end
   initial begin
      resetn = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      {out_ep_set, in_ep_set, device_event_set, code_addr, code_byte} = '0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      // Every register reads zero after reset, unmapped place too
      for (t = 0; t < 12; t++) begin
         bus(IDX_IN_FLAGS + 16'(t), 1'b0, 8'h00);
         check(rd_q, 8'h00);
      end
      bus(16'h0100, 1'b0, 8'h00);
      check(rd_q, 8'h00);
      bus(IDX_IN_EN, 1'b1, 8'hff);
      bus(IDX_OUT_EN, 1'b1, 8'hff);
      bus(IDX_DEV_EN, 1'b1, 8'hff);
      bus(IDX_DEV_EN, 1'b0, 8'h00);
      check(rd_q, 8'h1f);
      bus(IDX_CPU_EN, 1'b1, 8'h01);
      bus(IDX_IRQ_MASK, 1'b1, 8'h01);
      // Each source alone, in a random rotation
      r = {$random(seed)} % 21;
      for (t = 0; t < 21; t++) begin
         s = (t * 5 + r) % 21;
         base = pulse_cnt;
         raise(21'h1 << s);
         check(pulse_cnt, base + 8'h01);
         check({6'h0, cpu_usb_irq, irq}, 8'h03);
         bus(IDX_VECTOR, 1'b0, 8'h00);
         check(rd_q, 8'(slot(s) * 4));
         bus(fidx(s), 1'b1, ~fbit(s));
         bus(fidx(s), 1'b0, 8'h00);
         check(rd_q, fbit(s));
         bus(IDX_CPU_FLAGS, 1'b1, 8'h00);
         bus(fidx(s), 1'b1, fbit(s));
         bus(fidx(s), 1'b0, 8'h00);
         check(rd_q, 8'h00);
         bus(IDX_IRQ_STATUS, 1'b0, 8'h00);
         check(rd_q & 8'h07, 8'h01);
         @(posedge clk);
         check({6'h0, cpu_usb_irq, irq}, 8'h00);
      end
      // Two at once, extreme pair first; serviced flag first, then latch
      for (t = 0; t < 3; t++) begin
         a = t == 0 ? 0 : {$random(seed)} % 20;
         b = t == 0 ? 20 : a + 1 + {$random(seed)} % (20 - a);
         // IN and OUT slots interleave, so order the pair by slot
         if (slot(b) < slot(a)) begin
            s = a;
            a = b;
            b = s;
         end
         base = pulse_cnt;
         raise((21'h1 << a) | (21'h1 << b));
         check(pulse_cnt, base + 8'h01);
         bus(IDX_VECTOR, 1'b0, 8'h00);
         check(rd_q, 8'(slot(a) * 4));
         bus(IDX_CPU_FLAGS, 1'b1, 8'h00);
         bus(fidx(a), 1'b1, fbit(a));
         repeat (4) @(posedge clk);
         check(pulse_cnt, base + 8'h02);
         bus(IDX_VECTOR, 1'b0, 8'h00);
         check(rd_q, 8'(slot(b) * 4));
         bus(IDX_CPU_FLAGS, 1'b1, 8'h00);
         bus(fidx(b), 1'b1, fbit(b));
         repeat (4) @(posedge clk);
         check(pulse_cnt, base + 8'h02);
      end
      // Disabled source stays silent until enabled; irq masked, then unmasked
      bus(IDX_IRQ_MASK, 1'b1, 8'h00);
      bus(IDX_OUT_EN, 1'b1, 8'h00);
      base = pulse_cnt;
      raise(21'h1 << 20);
      check(pulse_cnt, base);
      bus(IDX_OUT_EN, 1'b1, 8'h80);
      repeat (4) @(posedge clk);
      check(pulse_cnt, base + 8'h01);
      check({7'h0, irq}, 8'h00);
      bus(IDX_IRQ_MASK, 1'b1, 8'h01);
      @(posedge clk);
      check({7'h0, irq}, 8'h01);
      // Out-of-order service: a pulse onto a still-set flag is lost
      raise(21'h1);
      check(pulse_cnt, base + 8'h02);
      bus(IDX_IRQ_STATUS, 1'b0, 8'h00);
      check(rd_q & 8'h02, 8'h02);
      bus(IDX_DEV_FLAGS, 1'b1, 8'h01);
      // Fetch of the vector slot, substitution off then on
      for (t = 0; t < 2; t++) begin
         bus(IDX_AV_CTRL, 1'b1, 8'(t));
         @(posedge clk);
         exp_b = 8'($random(seed));
         code_addr <= AUTOVEC_ADDR;
         code_byte <= exp_b;
         @(posedge clk);
         code_addr <= 16'h0044;
         @(posedge clk);
         check(fetch_byte, t == 1 ? 8'(slot(20) * 4) : exp_b);
      end
      // Only the enabled pass substituted, and that was recorded
      bus(IDX_IRQ_STATUS, 1'b0, 8'h00);
      check(rd_q & 8'h04, 8'h04);
      wrap_up;
   end
endmodule // usb_interrupt_aggregator_tb
